/* File: design/pmt_core.sv */
// Purpose: Program store, vectors, table read path and data memory.
// Assumes: Core commands and timer/A-D/time-base pulses are on core_clk;
//          the external interrupt pin is asynchronous.
// Notes:   A command is taken when cmd_valid is high and busy_ff is low
//          and no interrupt is acknowledged at that edge.
//
// Notes on behaviour
// - Program store holds 1024 words of 15 bits, addressed by PC.
// - Reset loads the PC with the reset vector.
// - Selected external edge branches to its vector if enabled, stack free.
// - External edge is falling, rising or both, set by control register.
// - Each timer overflow branches to its own vector if enabled, stack free.
// - A/D completion branches to the A/D vector if enabled, stack free.
// - Time base overflow branches to its vector if enabled, stack free.
// - Table pointer gives the low eight table address bits.
// - Current-page read takes address bits 9..8 from the PC.
// - Last-page read forces address bits 9..8 to one.
// - Low byte goes to the named location, high part to high register.
// - High register bits without a program bit read zero.
// - High register is read-only; writes leave it unchanged.
// - Every table read takes two instruction cycles.
// - Data memory is bytes from 00H, SFRs then general purpose.
// - Every general-purpose byte is readable and writable.
// - Bit set and clear change only the addressed bit.
// - Only the table high register is protected against writes.
// - Data memory is reachable indirectly through the memory pointer.
// - With stack full, request flag is kept and acknowledge waits.

`timescale 1ns/1ps

module pmt_core
    import pmt_pkg::*;
#(
    parameter int STACK_DEPTH = 6
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire pmt_op_t cmd_op,
    input wire logic [PM_AW-1:0] cmd_target,
    input wire logic [DM_AW-1:0] cmd_mem_addr,
    input wire logic [7:0] cmd_wdata,
    input wire logic [2:0] cmd_bit,
    input wire logic ext_int_pin,
    input wire logic tmr0_ovf,
    input wire logic tmr1_ovf,
    input wire logic adc_done,
    input wire logic tbase_ovf,
    input wire logic load_we,
    input wire logic [PM_AW-1:0] load_addr,
    input wire logic [PM_DW-1:0] load_word,
    output logic [PM_AW-1:0] pc_ff,
    output logic [PM_DW-1:0] fetch_word_ff,
    output logic [7:0] rd_data_ff,
    output logic cmd_taken_ff,
    output logic busy_ff,
    output logic int_ack_ff
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [PM_DW-1:0] pmem [PM_WORDS];
    logic [7:0] dmem [DM_GPR_WORDS];
    logic [PM_AW-1:0] stack [STACK_DEPTH];
    pmt_state_t state_ff, nxt_state;
    logic [PM_AW-1:0] nxt_pc, tbl_addr_ff, nxt_tbl_addr, st_val, vec;
    logic [DM_AW-1:0] tbl_dest_ff, nxt_tbl_dest, ea, wr_a;
    logic [7:0] mp_ff, nxt_mp, tp_ff, nxt_tp, th_ff, nxt_th;
    logic [7:0] en_ff, nxt_en, seq_en, nxt_rd_data, wr_v, rd_v;
    logic [4:0] flag_ff, nxt_flag, seq_flag, events, pending;
    logic [1:0] edge_ff, nxt_edge;
    logic [2:0] sp_ff, nxt_sp, st_idx;
    logic ext_s1_ff, ext_s2_ff, ext_prev_ff;
    logic ext_evt, stack_full, wr_go, dm_we, st_we, nxt_taken, nxt_ack;
    logic [5:0] dm_idx;
    logic [PM_DW-1:0] tbl_word;

    // ------------------------------------------------------------------
    // External pin synchroniser and edge select
    // ------------------------------------------------------------------
    // Two flops before use; the edge detector compares the second with a third, delayed copy
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ext_s1_ff <= 1'b0;
            ext_s2_ff <= 1'b0;
            ext_prev_ff <= 1'b0;
        end else begin
            ext_s1_ff <= ext_int_pin;
            ext_s2_ff <= ext_s1_ff;
            ext_prev_ff <= ext_s2_ff;
        end
    end
    // Selected edge of the synchronised pin
    assign ext_evt = ((edge_ff & EDGE_RISE) != 2'h0 && ext_s2_ff
                      && !ext_prev_ff)
                  || ((edge_ff & EDGE_FALL) != 2'h0 && !ext_s2_ff
                      && ext_prev_ff);
    assign events = {tbase_ovf, adc_done, tmr1_ovf, tmr0_ovf, ext_evt};
    assign pending = flag_ff & en_ff[NUM_INT:1]
                   & {NUM_INT{en_ff[EN_GLOBAL_BIT]}};
    assign stack_full = (sp_ff == 3'(STACK_DEPTH));
    // Fixed priority: external first, time base last
    always_comb begin
        vec = TBASE_VEC;
        if (pending[0]) begin
            vec = EXT_VEC;
        end else if (pending[1]) begin
            vec = TMR0_VEC;
        end else if (pending[2]) begin
            vec = TMR1_VEC;
        end else if (pending[3]) begin
            vec = ADC_VEC;
        end
    end
    // ------------------------------------------------------------------
    // Data memory read map
    // ------------------------------------------------------------------
    // Indirect slot resolves through the memory pointer
    assign ea = (cmd_mem_addr == ADDR_INDIRECT) ? mp_ff[DM_AW-1:0]
                                                : cmd_mem_addr;
    assign dm_idx = 6'(ea - DM_GPR_BASE);
    // SFRs first, then general purpose; holes read zero
    always_comb begin
        rd_v = 8'h00;
        unique case (ea)
            ADDR_MEM_PTR: rd_v = mp_ff;
            ADDR_TABLE_PTR: rd_v = tp_ff;
            ADDR_TABLE_HIGH: rd_v = th_ff;
            ADDR_INT_ENABLE: rd_v = en_ff;
            ADDR_INT_FLAG: rd_v = {3'h0, flag_ff};
            ADDR_EDGE_SEL: rd_v = {6'h00, edge_ff};
            default: begin
                if (ea >= DM_GPR_BASE && ea < 7'(DM_WORDS)) begin
                    rd_v = dmem[dm_idx];
                end
            end
        endcase
    end
    assign tbl_word = pmem[tbl_addr_ff];

    // ------------------------------------------------------------------
    // Sequencer: next values
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_pc = pc_ff;
        nxt_tbl_addr = tbl_addr_ff;
        nxt_tbl_dest = tbl_dest_ff;
        nxt_sp = sp_ff;
        nxt_th = th_ff;
        nxt_rd_data = rd_data_ff;
        nxt_taken = 1'b0;
        nxt_ack = 1'b0;
        seq_en = en_ff;
        seq_flag = flag_ff;
        wr_go = 1'b0;
        wr_a = ea;
        wr_v = cmd_wdata;
        st_we = 1'b0;
        st_idx = sp_ff;
        st_val = pc_ff;
        unique case (state_ff)
            ST_RUN: begin
                if (pending != 5'h00 && !stack_full) begin
                    // Acknowledge: push, vector, drop the flag
                    st_we = 1'b1;
                    nxt_sp = sp_ff + 3'h1;
                    nxt_pc = vec;
                    seq_flag = flag_ff & ~(pending & -pending);
                    seq_en[EN_GLOBAL_BIT] = 1'b0;
                    nxt_ack = 1'b1;
                    nxt_state = ST_BRANCH;
                end else if (cmd_valid) begin
                    nxt_taken = 1'b1;
                    nxt_pc = pc_ff + 10'h001;
                    unique case (cmd_op)
                        OP_NEXT: ;
                        OP_JUMP: begin
                            nxt_pc = cmd_target;
                            nxt_state = ST_BRANCH;
                        end
                        OP_CALL: begin
                            // Full stack overwrites the top level
                            st_we = 1'b1;
                            st_val = pc_ff + 10'h001;
                            if (stack_full) begin
                                st_idx = sp_ff - 3'h1;
                            end else begin
                                nxt_sp = sp_ff + 3'h1;
                            end
                            nxt_pc = cmd_target;
                            nxt_state = ST_BRANCH;
                        end
                        OP_RET, OP_RETURN_FROM_INTERRUPT: begin
                            if (sp_ff != 3'h0) begin
                                nxt_sp = sp_ff - 3'h1;
                                nxt_pc = stack[sp_ff - 3'h1];
                            end
                            if (cmd_op == OP_RETURN_FROM_INTERRUPT) begin
                                seq_en[EN_GLOBAL_BIT] = 1'b1;
                            end
                            nxt_state = ST_BRANCH;
                        end
                        OP_TBL_CUR, OP_TBL_LAST: begin
                            nxt_tbl_addr = {pc_ff[9:8], tp_ff};
                            if (cmd_op == OP_TBL_LAST) begin
                                nxt_tbl_addr[9:8] = LAST_PAGE;
                            end
                            nxt_tbl_dest = ea;
                            nxt_state = ST_TBL;
                        end
                        OP_RD: nxt_rd_data = rd_v;
                        OP_WR: wr_go = 1'b1;
                        OP_BSET: begin
                            wr_go = 1'b1;
                            wr_v = rd_v | (8'h01 << cmd_bit);
                        end
                        OP_BCLR: begin
                            wr_go = 1'b1;
                            wr_v = rd_v & ~(8'h01 << cmd_bit);
                        end
                        default: ;
                    endcase
                end
            end
            ST_TBL: begin
                // Second cycle: low byte to [m], high part to register
                wr_go = 1'b1;
                wr_a = tbl_dest_ff;
                wr_v = tbl_word[7:0];
                nxt_th = {1'b0, tbl_word[PM_DW-1:8]};
                nxt_state = ST_RUN;
            end
            ST_BRANCH: nxt_state = ST_RUN;
            default: nxt_state = ST_RUN;
        endcase
    end

    // ------------------------------------------------------------------
    // Register writes and request flags
    // ------------------------------------------------------------------
    always_comb begin
        nxt_en = seq_en;
        nxt_flag = seq_flag;
        nxt_mp = mp_ff;
        nxt_tp = tp_ff;
        nxt_edge = edge_ff;
        dm_we = 1'b0;
        if (wr_go) begin
            unique case (wr_a)
                ADDR_MEM_PTR: nxt_mp = wr_v;
                ADDR_TABLE_PTR: nxt_tp = wr_v;
                ADDR_TABLE_HIGH: ;
                ADDR_INT_ENABLE: nxt_en = wr_v;
                ADDR_INT_FLAG: nxt_flag = wr_v[4:0];
                ADDR_EDGE_SEL: nxt_edge = wr_v[1:0];
                default: dm_we = (wr_a >= DM_GPR_BASE)
                               && (wr_a < 7'(DM_WORDS));
            endcase
        end
        // New events win over any clear in the same cycle
        nxt_flag = nxt_flag | events;
    end

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_ff <= ST_RUN;
            pc_ff <= RESET_VEC;
            tbl_addr_ff <= RESET_VEC;
            tbl_dest_ff <= ADDR_INDIRECT;
            sp_ff <= 3'h0;
            mp_ff <= RST_BYTE;
            tp_ff <= RST_BYTE;
            th_ff <= RST_BYTE;
            en_ff <= RST_BYTE;
            flag_ff <= RST_FLAGS;
            edge_ff <= RST_EDGE;
            rd_data_ff <= RST_BYTE;
            cmd_taken_ff <= 1'b0;
            busy_ff <= 1'b0;
            int_ack_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            pc_ff <= nxt_pc;
            tbl_addr_ff <= nxt_tbl_addr;
            tbl_dest_ff <= nxt_tbl_dest;
            sp_ff <= nxt_sp;
            mp_ff <= nxt_mp;
            tp_ff <= nxt_tp;
            th_ff <= nxt_th;
            en_ff <= nxt_en;
            flag_ff <= nxt_flag;
            edge_ff <= nxt_edge;
            rd_data_ff <= nxt_rd_data;
            cmd_taken_ff <= nxt_taken;
            busy_ff <= (nxt_state != ST_RUN);
            int_ack_ff <= nxt_ack;
        end
    end
    // Memories and instruction fetch register
    always_ff @(posedge core_clk) begin
        if (load_we) begin
            pmem[load_addr] <= load_word;
        end
        if (dm_we) begin
            dmem[6'(wr_a - DM_GPR_BASE)] <= wr_v;
        end
        if (st_we) begin
            stack[st_idx] <= st_val;
        end
        fetch_word_ff <= pmem[nxt_pc];
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    reset_vector_a: assert property (@(posedge core_clk)
        rst |-> pc_ff == RESET_VEC)
        else $error("PC not at reset vector during reset");
    cur_page_addr_a: assert property (@(posedge core_clk)
        disable iff (rst)
        (state_ff == ST_RUN && nxt_taken && cmd_op == OP_TBL_CUR)
        |=> tbl_addr_ff == {$past(pc_ff[9:8]), $past(tp_ff)})
        else $error("Current page table address wrong");
    last_page_addr_a: assert property (@(posedge core_clk)
        disable iff (rst)
        (nxt_taken && cmd_op == OP_TBL_LAST)
        |=> tbl_addr_ff == {LAST_PAGE, $past(tp_ff)})
        else $error("Last page table address wrong");
    table_two_cycle_a: assert property (@(posedge core_clk)
        disable iff (rst)
        (nxt_taken && (cmd_op == OP_TBL_CUR || cmd_op == OP_TBL_LAST))
        |=> busy_ff ##1 !busy_ff)
        else $error("Table read not two cycles");
    high_byte_load_a: assert property (@(posedge core_clk)
        disable iff (rst)
        state_ff == ST_TBL |=> th_ff == {1'b0, $past(tbl_word[14:8])}
            && th_ff[7] == 1'b0)
        else $error("High byte register load wrong");
    high_byte_ro_a: assert property (@(posedge core_clk)
        disable iff (rst)
        (wr_go && wr_a == ADDR_TABLE_HIGH && state_ff == ST_RUN)
        |=> $stable(th_ff))
        else $error("High byte register changed by write");
    full_stack_hold_a: assert property (@(posedge core_clk)
        disable iff (rst)
        (stack_full && (flag_ff & en_ff[5:1]) != 5'h00)
        |=> !int_ack_ff && flag_ff != 5'h00)
        else $error("Interrupt taken with full stack");
    ext_vector_a: assert property (@(posedge core_clk)
        disable iff (rst)
        int_ack_ff && $past(pending[0]) |-> pc_ff == EXT_VEC)
        else $error("External interrupt vector wrong");
    pointer_kept_a: assert property (@(posedge core_clk)
        disable iff (rst)
        (nxt_taken && cmd_op == OP_TBL_LAST && ea != ADDR_TABLE_PTR)
        |=> $stable(tp_ff) ##1 $stable(tp_ff))
        else $error("Table read changed the pointer");

endmodule : pmt_core

/* File: shared/pmt_pkg.sv */
// Purpose: Shared constants and types for the program memory and table
//          read block.
// Assumes: One instruction cycle per core_clk edge.
// Notes:   Data memory addresses are 7 bits; GPR area follows the SFRs.

package pmt_pkg;

    // ------------------------------------------------------------------
    // Memory geometry
    // ------------------------------------------------------------------
    localparam int PM_WORDS = 1024;
    localparam int PM_AW = 10;
    localparam int PM_DW = 15;
    localparam int DM_AW = 7;
    localparam int DM_WORDS = 96;
    localparam logic [DM_AW-1:0] DM_GPR_BASE = 7'h20;
    localparam int DM_GPR_WORDS = 64;

    // ------------------------------------------------------------------
    // Special-function register offsets
    // ------------------------------------------------------------------
    localparam logic [DM_AW-1:0] ADDR_INDIRECT = 7'h00;
    localparam logic [DM_AW-1:0] ADDR_MEM_PTR = 7'h01;
    localparam logic [DM_AW-1:0] ADDR_TABLE_PTR = 7'h07;
    localparam logic [DM_AW-1:0] ADDR_TABLE_HIGH = 7'h08;
    localparam logic [DM_AW-1:0] ADDR_INT_ENABLE = 7'h0B;
    localparam logic [DM_AW-1:0] ADDR_EDGE_SEL = 7'h1B;
    localparam logic [DM_AW-1:0] ADDR_INT_FLAG = 7'h1C;

    // ------------------------------------------------------------------
    // Reset values and field layouts
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [4:0] RST_FLAGS = 5'h00;
    localparam logic [1:0] RST_EDGE = 2'h0;
    localparam int EN_GLOBAL_BIT = 0;
    localparam int NUM_INT = 5;
    localparam logic [1:0] LAST_PAGE = 2'h3;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;

    // ------------------------------------------------------------------
    // Vectors: reset, external, timer 0, timer 1, A/D, time base
    // ------------------------------------------------------------------
    localparam logic [PM_AW-1:0] RESET_VEC = 10'h000;
    localparam logic [PM_AW-1:0] EXT_VEC = 10'h004;
    localparam logic [PM_AW-1:0] TMR0_VEC = 10'h008;
    localparam logic [PM_AW-1:0] TMR1_VEC = 10'h00C;
    localparam logic [PM_AW-1:0] ADC_VEC = 10'h010;
    localparam logic [PM_AW-1:0] TBASE_VEC = 10'h014;

    // Core commands
    typedef enum logic [3:0] {
        OP_NEXT, OP_JUMP, OP_CALL, OP_RET, OP_RETURN_FROM_INTERRUPT, OP_TBL_CUR,
        OP_TBL_LAST, OP_RD, OP_WR, OP_BSET, OP_BCLR
    } pmt_op_t;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_RUN, ST_TBL, ST_BRANCH
    } pmt_state_t;

endpackage : pmt_pkg

/* File: tb/pmt_core_model.sv */
// Purpose: Processor-side command source for the program memory block.
// Assumes: A command is taken at an edge where busy_ff was low.
// Notes:   Released command fields except cmd_op show inverted data, not the old value.

`timescale 1ns/1ps

module pmt_core_model
    import pmt_pkg::*;
(
    input wire logic core_clk,
    input wire logic busy_ff,
    input wire logic cmd_taken_ff,
    output logic cmd_valid,
    output pmt_op_t cmd_op,
    output logic [PM_AW-1:0] cmd_target,
    output logic [DM_AW-1:0] cmd_mem_addr,
    output logic [7:0] cmd_wdata,
    output logic [2:0] cmd_bit
);
    int pace = 0; // Idle cycles before each command, for slow issue

    // Idle bus at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_op = OP_NEXT;
        cmd_target = '0;
        cmd_mem_addr = '0;
        cmd_wdata = '0;
        cmd_bit = '0;
    end

    // ----------------------------------------------------------------
    // Command issue
    // ----------------------------------------------------------------
    // Hold a command until an edge takes it, then release the fields
    task automatic exec(input pmt_op_t op, input logic [PM_AW-1:0] tgt,
            input logic [DM_AW-1:0] addr, input logic [7:0] wd,
            input logic [2:0] b, output logic ok, output logic acc,
            output logic busy2);
        ok = 1'b0;
        repeat (pace) @(posedge core_clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_target <= tgt;
        cmd_mem_addr <= addr;
        cmd_wdata <= wd;
        cmd_bit <= b;
        for (int k = 0; k < 8 && !ok; k++) begin
            @(posedge core_clk);
            ok = (busy_ff === 1'b0);
        end
        cmd_valid <= 1'b0;
        cmd_target <= ~tgt;
        cmd_mem_addr <= ~addr;
        cmd_wdata <= ~wd;
        cmd_bit <= ~b;
        @(posedge core_clk);
        acc = cmd_taken_ff;
        busy2 = busy_ff;
    endtask
endmodule // pmt_core_model

/* File: tb/program_memory_table_read_test.sv */
// Purpose: Self-checking bench for the program memory and table block.
// Assumes: Interrupt sources stay idle while commands are in flight,
//          except where the stack is full.
// Notes:   Main-line table reads run with interrupts disabled.

`timescale 1ns/1ps

module program_memory_table_read_test
    import pmt_pkg::*;
;
    localparam int DEPTH = 6;
    logic core_clk = 1'b0;
    logic rst = 1'b0;
    logic ext_int_pin = 1'b0;
    logic [3:0] ev = 4'h0;
    logic load_we = 1'b0;
    logic [PM_AW-1:0] load_addr = '0;
    logic [PM_DW-1:0] load_word = '0;
    logic cmd_valid;
    pmt_op_t cmd_op;
    logic [PM_AW-1:0] cmd_target;
    logic [DM_AW-1:0] cmd_mem_addr;
    logic [7:0] cmd_wdata;
    logic [2:0] cmd_bit;
    logic [PM_AW-1:0] pc_ff;
    logic [PM_DW-1:0] fetch_word_ff;
    logic [7:0] rd_data_ff;
    logic cmd_taken_ff, busy_ff, int_ack_ff, got;
    logic [PM_AW-1:0] vecs [4];
    int n_errors = 0;
    int compares = 0;

    // 10 MHz instruction clock
    always #50 core_clk = ~core_clk;

    pmt_core #(.STACK_DEPTH(DEPTH)) dut (.core_clk(core_clk), .rst(rst),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_target(cmd_target),
        .cmd_mem_addr(cmd_mem_addr), .cmd_wdata(cmd_wdata),
        .cmd_bit(cmd_bit), .ext_int_pin(ext_int_pin), .tmr0_ovf(ev[0]),
        .tmr1_ovf(ev[1]), .adc_done(ev[2]), .tbase_ovf(ev[3]),
        .load_we(load_we), .load_addr(load_addr), .load_word(load_word),
        .pc_ff(pc_ff), .fetch_word_ff(fetch_word_ff),
        .rd_data_ff(rd_data_ff), .cmd_taken_ff(cmd_taken_ff),
        .busy_ff(busy_ff), .int_ack_ff(int_ack_ff));

    pmt_core_model core (.core_clk(core_clk), .busy_ff(busy_ff),
        .cmd_taken_ff(cmd_taken_ff), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_target(cmd_target),
        .cmd_mem_addr(cmd_mem_addr), .cmd_wdata(cmd_wdata),
        .cmd_bit(cmd_bit));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Print counts and verdict, then stop
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
            input string what);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s seen %h want %h", $time, what,
                seen, exp);
        end
    endtask

    // Issue one command and check take pulse and second-cycle busy
    task automatic run(input pmt_op_t op, input logic [PM_AW-1:0] tgt,
            input logic [DM_AW-1:0] a, input logic [7:0] d,
            input logic [2:0] b);
        logic ok, acc, bz, two;
        two = (op >= OP_JUMP && op <= OP_TBL_LAST);
        core.exec(op, tgt, a, d, b, ok, acc, bz);
        if (ok !== 1'b1) begin
            n_errors++;
            $display("wrong value at %0t: command not taken", $time);
            wrap_up();
        end
        check(16'(acc), 16'h0001, "taken pulse");
        check(16'(bz), 16'(two), "second cycle busy");
    endtask

    task automatic wr(input logic [DM_AW-1:0] a, input logic [7:0] d);
        run(OP_WR, '0, a, d, '0);
    endtask

    task automatic rd_chk(input logic [DM_AW-1:0] a, input logic [7:0] e);
        run(OP_RD, '0, a, '0, '0);
        check(16'(rd_data_ff), 16'(e), "read data");
    endtask

    // Program store write; caller releases load_we
    task automatic load(input logic [PM_AW-1:0] a, input logic [14:0] w);
        load_we <= 1'b1;
        load_addr <= a;
        load_word <= w;
        @(posedge core_clk);
    endtask

    // One-cycle event pulse
    task automatic pulse(input int i);
        ev[i] <= 1'b1;
        @(posedge core_clk);
        ev[i] <= 1'b0;
    endtask

    // Bounded wait for an acknowledge pulse
    task automatic wait_ack(output logic g);
        g = 1'b0;
        for (int k = 0; k < 12 && !g; k++) begin
            @(posedge core_clk);
            g = (int_ack_ff === 1'b1);
        end
    endtask

    task automatic do_reset();
        rst <= 1'b1;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
    endtask

    // Overall run limit
    initial begin
        #3_000_000;
        n_errors++;
        $display("wrong value at %0t: run timed out", $time);
        wrap_up();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        vecs = '{TMR0_VEC, TMR1_VEC, ADC_VEC, TBASE_VEC};
        @(posedge core_clk);
        do_reset();
        check(16'(pc_ff), 16'(RESET_VEC), "reset pc");
        load(10'h306, 15'h7FA5);
        load(10'h105, 15'h2C3B);
        load(10'h3FF, 15'h4321);
        load_we <= 1'b0;
        run(OP_JUMP, 10'h3FF, '0, '0, '0);
        repeat (2) @(posedge core_clk);
        check(16'(pc_ff), 16'h03FF, "jump pc");
        check(16'(fetch_word_ff), 16'h4321, "top word");
        run(OP_NEXT, '0, '0, '0, '0);
        check(16'(pc_ff), 16'h0000, "next pc wraps");
        $display("test store finished");
        // Table reads, last page then current page
        core.pace = 2;
        wr(ADDR_TABLE_PTR, 8'h06);
        run(OP_TBL_LAST, '0, 7'h20, '0, '0);
        rd_chk(7'h20, 8'hA5);
        rd_chk(ADDR_TABLE_HIGH, 8'h7F);
        rd_chk(ADDR_TABLE_PTR, 8'h06);
        wr(ADDR_TABLE_HIGH, 8'h00);
        rd_chk(ADDR_TABLE_HIGH, 8'h7F);
        core.pace = 0;
        run(OP_JUMP, 10'h1F0, '0, '0, '0);
        wr(ADDR_TABLE_PTR, 8'h05);
        run(OP_TBL_CUR, '0, 7'h21, '0, '0);
        rd_chk(7'h21, 8'h3B);
        rd_chk(ADDR_TABLE_HIGH, 8'h2C);
        $display("test table finished");
        // General-purpose area, all locations
        for (int a = 0; a < DM_GPR_WORDS; a++)
            wr(DM_GPR_BASE + 7'(a), 8'(a * 3 + 1));
        for (int a = 0; a < DM_GPR_WORDS; a++)
            rd_chk(DM_GPR_BASE + 7'(a), 8'(a * 3 + 1));
        // Single-bit set then clear
        wr(7'h40, 8'h00);
        for (int i = 0; i < 8; i++) begin
            run(OP_BSET, '0, 7'h40, '0, 3'(i));
            rd_chk(7'h40, 8'((2 << i) - 1));
        end
        for (int i = 0; i < 8; i++) begin
            run(OP_BCLR, '0, 7'h40, '0, 3'(i));
            rd_chk(7'h40, 8'(8'hFF << (i + 1)));
        end
        // Indirect access
        wr(ADDR_MEM_PTR, 8'h25);
        wr(ADDR_INDIRECT, 8'h5C);
        rd_chk(7'h25, 8'h5C);
        rd_chk(ADDR_INDIRECT, 8'h5C);
        $display("test data finished");
        // External edge modes: rising, falling, both
        for (int m = 1; m < 4; m++) begin
            wr(ADDR_EDGE_SEL, 8'(m));
            wr(ADDR_INT_ENABLE, 8'h03);
            for (int e = 0; e < 2; e++) begin
                ext_int_pin <= (e == 0);
                wait_ack(got);
                check(16'(got), 16'((m >> e) & 1), "edge");
                if (got) begin
                    check(16'(pc_ff), 16'(EXT_VEC), "ext vec");
                    run(OP_RETURN_FROM_INTERRUPT, '0, '0, '0, '0);
                end
            end
        end
        // Internal sources, each to its own vector
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_INT_ENABLE, (8'h04 << i) | 8'h01);
            pulse(i);
            wait_ack(got);
            check(16'(got), 16'h0001, "ack");
            check(16'(pc_ff), 16'(vecs[i]), "vec");
            run(OP_RETURN_FROM_INTERRUPT, '0, '0, '0, '0);
        end
        // Source not enabled: flag only
        wr(ADDR_INT_ENABLE, 8'h01);
        pulse(0);
        wait_ack(got);
        check(16'(got), 16'h0000, "masked ack");
        rd_chk(ADDR_INT_FLAG, 8'h02);
        wr(ADDR_INT_FLAG, 8'h00);
        $display("test interrupt finished");
        // Full stack holds the request until a return
        wr(ADDR_INT_ENABLE, 8'h09);
        for (int k = 0; k < DEPTH; k++)
            run(OP_CALL, 10'h050, '0, '0, '0);
        pulse(1);
        wait_ack(got);
        check(16'(got), 16'h0000, "full stack ack");
        rd_chk(ADDR_INT_FLAG, 8'h04);
        run(OP_RET, '0, '0, '0, '0);
        wait_ack(got);
        check(16'(got), 16'h0001, "late ack");
        check(16'(pc_ff), 16'(TMR1_VEC), "late vec");
        do_reset();
        check(16'(pc_ff), 16'(RESET_VEC), "second reset pc");
        $display("test stack finished");
        wrap_up();
    end
endmodule // program_memory_table_read_test
